// >>> include/stpidx_pkg.sv
// Constants, types and helpers for the step/direction indexer
package stpidx_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 20;
  localparam int STEP_FLT_NS = 200;
  localparam int RES_FLT_NS = 1250;
  localparam int STB_FLT_NS = 940;
  localparam int INIT_FLT_NS = 625;
  localparam int WAKE_NS = 7500;
  localparam int LVL_FLT_CYC = 1;
  localparam int STEP_FLT_CYC = (STEP_FLT_NS + CLK_NS - 1) / CLK_NS;
  localparam int RES_FLT_CYC = (RES_FLT_NS + CLK_NS - 1) / CLK_NS;
  localparam int STB_FLT_CYC = (STB_FLT_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_FLT_CYC = (INIT_FLT_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WARM_W = $clog2(WAKE_CYC + 1);

  // ****************************************
  // Angle and current
  // ****************************************
  localparam logic [6:0] INIT_IDX = 7'h10;
  localparam logic [6:0] QTR_IDX = 7'h20;
  localparam logic [6:0] FULL_OFF = 7'h10;
  localparam logic [4:0] DIAG_POS = 5'h10;
  localparam logic signed [7:0] FULL_PCT = 8'sh64;
  localparam logic [6:0] MAG [0:32] = '{
    7'h64, 7'h64, 7'h64, 7'h63, 7'h62, 7'h61, 7'h60, 7'h5e, 7'h5c,
    7'h5a, 7'h58, 7'h56, 7'h53, 7'h50, 7'h4d, 7'h4a, 7'h47, 7'h43,
    7'h3f, 7'h3c, 7'h38, 7'h34, 7'h2f, 7'h2b, 7'h26, 7'h22, 7'h1d,
    7'h19, 7'h14, 7'h0f, 7'h0a, 7'h05, 7'h00};

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [1:0] LVL_RST = 2'h0;
  localparam logic [0:0] BIT_RST = 1'h0;
  localparam logic signed [7:0] INIT_PCT = 8'sh47;

  // Order matches the select code {sel0, sel1, sel2}
  typedef enum logic [2:0] {
    RES_STBY, RES_FULL, RES_HALFA, RES_QUART,
    RES_HALFB, RES_8, RES_16, RES_32
  } stpidx_res_type;

  function automatic logic [6:0] stpidx_inc(input stpidx_res_type r);
    case (r)
      RES_32: stpidx_inc = 7'h01;
      RES_16: stpidx_inc = 7'h02;
      RES_8: stpidx_inc = 7'h04;
      RES_QUART: stpidx_inc = 7'h08;
      RES_HALFA, RES_HALFB: stpidx_inc = 7'h10;
      RES_FULL: stpidx_inc = 7'h20;
      default: stpidx_inc = 7'h00;
    endcase
  endfunction : stpidx_inc

  function automatic logic [6:0] stpidx_off(input stpidx_res_type r);
    stpidx_off = (r == RES_FULL) ? FULL_OFF : 7'h00;
  endfunction : stpidx_off

  function automatic logic signed [7:0] stpidx_cos(input logic [6:0] a);
    logic [5:0] r;
    logic [5:0] m;
    r = {1'b0, a[4:0]};
    m = 6'h20 - r;
    case (a[6:5])
      2'h0: stpidx_cos = $signed({1'b0, MAG[r]});
      2'h1: stpidx_cos = -$signed({1'b0, MAG[m]});
      2'h2: stpidx_cos = -$signed({1'b0, MAG[r]});
      default: stpidx_cos = $signed({1'b0, MAG[m]});
    endcase
  endfunction : stpidx_cos

endpackage : stpidx_pkg

// >>> include/stpidx_flt_if.sv
// Raw pin level in, filtered level out, between top and filter
`timescale 1ns/1ps
`default_nettype none
interface stpidx_flt_if #(parameter int W = 1);
  logic [W-1:0] pin;
  logic [W-1:0] flt;
  modport filt(input pin, output flt);
  modport user(output pin, input flt);
endinterface : stpidx_flt_if
`default_nettype wire

// >>> src/stpidx_filt.sv
// Two-stage synchroniser followed by a stable-for-N-cycles filter
`timescale 1ns/1ps
`default_nettype none
module stpidx_filt
  import stpidx_pkg::*;
#(
  parameter int W = 1,
  parameter int CNT = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  stpidx_flt_if.filt f
);

  localparam int CW = $clog2(CNT + 1);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] flt;
    logic [CW-1:0] cnt;
  } stpidx_filt_state_type;

  stpidx_filt_state_type q;
  stpidx_filt_state_type d;

  // ****************************************
  // Filter
  // ****************************************
  // Any bounce restarts the count, so a level must hold CNT + 1 cycles
  always_comb begin
    d = q;
    d.s1 = f.pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.flt || q.s2 != q.s3) begin
      d.cnt = '0;
    end else if (q.cnt == CW'(CNT - 1)) begin
      d.flt = q.s2;
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '{s1: RST, s2: RST, s3: RST, flt: RST, cnt: '0};
    end else begin
      q <= d;
    end
  end

  assign f.flt = q.flt;

  a_filt_settle: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (q.flt != $past(q.flt)) |-> $past(q.cnt) == CW'(CNT - 1))
    else $error("filtered level changed before its window");

  a_filt_bounce: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (q.s2 != q.s3) |=> (q.flt == $past(q.flt)))
    else $error("filtered level followed a bouncing input");

endmodule : stpidx_filt
`default_nettype wire

// >>> src/stpidx_top.sv
// Step/direction indexer: angle counter, current table and bridge control
`timescale 1ns/1ps
`default_nettype none
module stpidx_top
  import stpidx_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_step_clk,
  input wire logic i_rotation_direction,
  input wire logic i_out_en,
  input wire logic i_step_res_sel0,
  input wire logic i_step_res_sel1,
  input wire logic i_step_res_sel2,
  input wire logic i_angle_init,
  input wire logic i_home_angle_flag,
  output logic o_home_angle_flag,
  output logic o_home_angle_flag_oe,
  output logic o_internal_oscillator,
  output logic o_bridge_oe,
  output logic o_a_pos,
  output logic o_a_neg,
  output logic o_b_pos,
  output logic o_b_neg,
  output logic signed [7:0] o_cur_a,
  output logic signed [7:0] o_cur_b
);

  typedef struct packed {
    logic [6:0] idx;
    stpidx_res_type last_res;
    logic step_prev;
    logic [WARM_W-1:0] warm;
    logic signed [7:0] cur_a;
    logic signed [7:0] cur_b;
    logic a_pos;
    logic a_neg;
    logic b_pos;
    logic b_neg;
    logic oe;
    logic home_oe;
    logic osc;
  } stpidx_top_state_type;

  stpidx_top_state_type q;
  stpidx_top_state_type d;

  // ****************************************
  // Input filters
  // ****************************************
  stpidx_flt_if #(.W(3)) sel_if ();
  stpidx_flt_if #(.W(3)) stb_if ();
  stpidx_flt_if #(.W(1)) init_if ();
  stpidx_flt_if #(.W(1)) step_if ();
  stpidx_flt_if #(.W(2)) lvl_if ();

  assign sel_if.pin = {i_step_res_sel0, i_step_res_sel1, i_step_res_sel2};
  assign stb_if.pin = {i_step_res_sel0, i_step_res_sel1, i_step_res_sel2};
  assign init_if.pin = i_angle_init;
  assign step_if.pin = i_step_clk;
  assign lvl_if.pin = {i_rotation_direction, i_out_en};

  stpidx_filt #(.W(3), .CNT(RES_FLT_CYC), .RST(SEL_RST)) u_sel_filt (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .f(sel_if.filt)
  );

  stpidx_filt #(.W(3), .CNT(STB_FLT_CYC), .RST(SEL_RST)) u_stb_filt (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .f(stb_if.filt)
  );

  stpidx_filt #(.W(1), .CNT(INIT_FLT_CYC), .RST(BIT_RST)) u_init_filt (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .f(init_if.filt)
  );

  // Stands in for the analog glitch filter on the step pin
  stpidx_filt #(.W(1), .CNT(STEP_FLT_CYC), .RST(BIT_RST)) u_step_filt (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .f(step_if.filt)
  );

  stpidx_filt #(.W(2), .CNT(LVL_FLT_CYC), .RST(LVL_RST)) u_lvl_filt (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .f(lvl_if.filt)
  );

  // ****************************************
  // Decoded controls
  // ****************************************
  stpidx_res_type res;
  logic stb_f;
  logic init_f;
  logic step_f;
  logic dir_f;
  logic en_f;
  logic active;
  logic step_rise;
  logic [6:0] inc;
  logic [6:0] off;
  logic [6:0] snap;
  logic full_pwr;

  assign res = stpidx_res_type'(sel_if.flt);
  assign stb_f = (stb_if.flt == 3'h0);
  assign init_f = init_if.flt[0];
  assign step_f = step_if.flt[0];
  assign dir_f = lvl_if.flt[1];
  assign en_f = lvl_if.flt[0];
  assign active = !stb_f && (q.warm == '0);
  assign step_rise = step_f && !q.step_prev;
  assign inc = stpidx_inc(res);
  assign off = stpidx_off(res);
  assign full_pwr = (res == RES_FULL) || (res == RES_HALFA);

  // Nearest grid point of the new resolution, ties go forward
  assign snap = ((q.idx - off + (inc >> 1)) & ~(inc - 7'h01)) + off;

  // ****************************************
  // Indexer
  // ****************************************
  always_comb begin
    d = q;
    d.step_prev = step_f;
    // Warm-up counter is held full in standby and drains after wake
    if (stb_f) begin
      d.warm = WARM_W'(WAKE_CYC);
    end else if (q.warm != '0) begin
      d.warm = q.warm - 1'b1;
    end
    if (init_f) begin
      d.idx = INIT_IDX;
      d.last_res = res;
    end else if (step_rise && active) begin
      if (res != q.last_res) begin
        d.idx = snap;
      end else if (dir_f) begin
        d.idx = q.idx + inc;
      end else begin
        d.idx = q.idx - inc;
      end
      d.last_res = res;
    end
    d.cur_a = stpidx_cos(d.idx);
    d.cur_b = stpidx_cos(d.idx - QTR_IDX);
    // Half step a and full step run the diagonals at full current
    if (full_pwr && d.idx[4:0] == DIAG_POS) begin
      d.cur_a = d.cur_a[7] ? -FULL_PCT : FULL_PCT;
      d.cur_b = d.cur_b[7] ? -FULL_PCT : FULL_PCT;
    end
    d.oe = en_f && active;
    d.a_pos = d.oe && (!d.cur_a[7] == dir_f);
    d.a_neg = d.oe && (!d.cur_a[7] != dir_f);
    d.b_pos = d.oe && (!d.cur_b[7] == dir_f);
    d.b_neg = d.oe && (!d.cur_b[7] != dir_f);
    d.home_oe = (d.idx == INIT_IDX);
    d.osc = !stb_f;
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '{
        idx: INIT_IDX,
        last_res: RES_STBY,
        step_prev: 1'b0,
        warm: WARM_W'(WAKE_CYC),
        cur_a: INIT_PCT,
        cur_b: INIT_PCT,
        a_pos: 1'b0,
        a_neg: 1'b0,
        b_pos: 1'b0,
        b_neg: 1'b0,
        oe: 1'b0,
        home_oe: 1'b1,
        osc: 1'b0
      };
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Open drain: only ever pulls low
  assign o_home_angle_flag = 1'b0;
  assign o_home_angle_flag_oe = q.home_oe;
  assign o_internal_oscillator = q.osc;
  assign o_bridge_oe = q.oe;
  assign o_a_pos = q.a_pos;
  assign o_a_neg = q.a_neg;
  assign o_b_pos = q.b_pos;
  assign o_b_neg = q.b_neg;
  assign o_cur_a = q.cur_a;
  assign o_cur_b = q.cur_b;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  a_step_fwd: assert property (
    step_rise && active && !init_f && dir_f && res == q.last_res
    |=> q.idx == $past(q.idx + inc))
    else $error("forward step did not advance the angle");

  a_step_hold: assert property (
    !step_rise && !init_f |=> q.idx == $past(q.idx))
    else $error("angle moved without a rising step edge");

  a_bridge_off: assert property (
    !en_f |=> !o_bridge_oe && !o_a_pos && !o_a_neg && !o_b_pos && !o_b_neg)
    else $error("bridge driven while enable low");

  a_polarity_dir: assert property (
    o_bridge_oe && o_cur_a > 8'sh00 |-> o_a_pos == $past(dir_f) && o_a_neg != o_a_pos)
    else $error("bridge polarity does not follow direction");

  a_reverse_step: assert property (
    step_rise && active && !init_f && !dir_f && res == q.last_res
    |=> q.idx == $past(q.idx - inc))
    else $error("reverse step did not retreat the angle");

  a_phase_quad: assert property (
    q.idx == 7'h00 |-> o_cur_a == FULL_PCT && o_cur_b == 8'sh00)
    else $error("phase currents not in quadrature");

  a_res_decode: assert property (
    sel_if.flt == 3'h7 |-> inc == 7'h01 ##0 off == 7'h00)
    else $error("finest resolution decoded wrongly");

  a_standby_off: assert property (
    stb_f |=> !o_internal_oscillator && !o_bridge_oe)
    else $error("standby left oscillator or bridge running");

  a_wake_wait: assert property (
    stb_f ##1 !stb_f |-> !active [*8])
    else $error("outputs came back before warm-up");

  a_snap_grid: assert property (
    step_rise && active && !init_f && res != q.last_res
    |=> ((q.idx - $past(off)) & ($past(inc) - 7'h01)) == 7'h00)
    else $error("resolution change did not land on the new grid");

  a_init_force: assert property (
    init_f |=> q.idx == INIT_IDX && o_home_angle_flag_oe)
    else $error("init did not force the initial angle");

  a_init_level: assert property (
    init_f && !full_pwr ##1 !full_pwr |-> o_cur_a == INIT_PCT && o_cur_b == INIT_PCT)
    else $error("initial current not 71 percent");

  a_home_flag: assert property (
    o_home_angle_flag_oe == (q.idx == INIT_IDX) && !o_home_angle_flag)
    else $error("home flag disagrees with angle");

  a_init_full: assert property (
    init_f && full_pwr |=> o_cur_a == FULL_PCT && o_cur_b == FULL_PCT)
    else $error("initial current not 100 percent in coarse modes");

  a_polarity_b: assert property (
    o_bridge_oe && o_cur_b > 8'sh00 |-> o_b_pos == $past(dir_f) && o_b_neg != o_b_pos)
    else $error("phase b polarity does not follow direction");

  a_step_refused: assert property (
    step_rise && !active && !init_f |=> q.idx == $past(q.idx))
    else $error("step taken during standby or warm-up");

  a_osc_run: assert property (
    !stb_f |=> o_internal_oscillator)
    else $error("oscillator stopped outside standby");

  a_table_ninety: assert property (
    q.idx == 7'h20 |-> o_cur_a == 8'sh00 && o_cur_b == FULL_PCT)
    else $error("table wrong at ninety degrees");

endmodule : stpidx_top
`default_nettype wire

// >>> tb/stpidx_host.sv
// Host model that drives the indexer's step, direction, enable, select and init pins
`timescale 1ns/1ps
`default_nettype none
module stpidx_host (
  input wire logic i_mclk,
  output logic o_step_clk,
  output logic o_dir,
  output logic o_en,
  output logic [2:0] o_sel,
  output logic o_init
);
  initial begin
    o_step_clk = 1'b0;
    o_dir = 1'b1;
    o_en = 1'b0;
    o_sel = 3'h7;
    o_init = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : wait_clk

  // Widths stay above the step filter, otherwise the pulse is lost
  task automatic step(input int hi, input int lo);
    o_step_clk <= 1'b1;
    wait_clk(hi);
    o_step_clk <= 1'b0;
    wait_clk(lo);
  endtask : step

  task automatic set_pins(input logic d, input logic e, input logic [2:0] s, input logic r,
      input int n);
    o_dir <= d;
    o_en <= e;
    o_sel <= s;
    o_init <= r;
    wait_clk(n);
  endtask : set_pins
endmodule : stpidx_host
`default_nettype wire

// >>> tb/step_dir_indexer_control_test.sv
// Self-checking bench: indexer against a reference angle and current model
`timescale 1ns/1ps
`default_nettype none
module step_dir_indexer_control_test;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic step_pin, dir_pin, en_pin, init_pin, flag_pin;
  logic [2:0] sel_pin;
  logic flag_oe, flag_q, osc, bridge_oe, a_pos, a_neg, b_pos, b_neg;
  logic signed [7:0] cur_a, cur_b;
  int n_mismatch = 0;
  int compares = 0;
  int idx = 16;
  int last = 0;
  int res = 7;
  int stby = 0;
  int mag [0:32] = '{100, 100, 100, 99, 98, 97, 96, 94, 92, 90, 88, 86, 83, 80, 77, 74, 71,
    67, 63, 60, 56, 52, 47, 43, 38, 34, 29, 25, 20, 15, 10, 5, 0};
  int incs [0:7] = '{0, 32, 16, 8, 16, 4, 2, 1};
  int codes [0:7] = '{7, 6, 5, 3, 4, 2, 1, 7};
  int inits [0:1] = '{2, 7};

  always #10 i_mclk = ~i_mclk;
  // Pull-up on the flag pad: released reads high
  assign flag_pin = flag_oe ? flag_q : 1'b1;

  stpidx_host host (.i_mclk(i_mclk), .o_step_clk(step_pin), .o_dir(dir_pin), .o_en(en_pin),
    .o_sel(sel_pin), .o_init(init_pin));
  stpidx_top dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_step_clk(step_pin),
    .i_rotation_direction(dir_pin), .i_out_en(en_pin), .i_step_res_sel0(sel_pin[2]),
    .i_step_res_sel1(sel_pin[1]), .i_step_res_sel2(sel_pin[0]), .i_angle_init(init_pin),
    .i_home_angle_flag(flag_pin), .o_home_angle_flag(flag_q), .o_home_angle_flag_oe(flag_oe),
    .o_internal_oscillator(osc), .o_bridge_oe(bridge_oe), .o_a_pos(a_pos), .o_a_neg(a_neg),
    .o_b_pos(b_pos), .o_b_neg(b_neg), .o_cur_a(cur_a), .o_cur_b(cur_b));

  // ****************************************
  // Reference model and checks
  // ****************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  function automatic int cosv(input int a);
    int r;
    r = a % 32;
    case (a / 32)
      0: return mag[r];
      1: return -mag[32 - r];
      2: return -mag[r];
      default: return mag[32 - r];
    endcase
  endfunction : cosv

  task automatic check_phase(input string name, input int e, input logic p, input logic n);
    logic on;
    on = en_pin & (stby == 0);
    if (e != 0) begin
      check({name, "_pos"}, {7'h0, p}, {7'h0, on & ((e > 0) == dir_pin)});
      check({name, "_neg"}, {7'h0, n}, {7'h0, on & ((e > 0) != dir_pin)});
    end
  endtask : check_phase

  task automatic check_all();
    int ea;
    int eb;
    ea = cosv(idx);
    eb = cosv((idx + 96) % 128);
    if ((res == 1 || res == 2) && idx % 32 == 16) begin
      ea = (ea > 0) ? 100 : -100;
      eb = (eb > 0) ? 100 : -100;
    end
    check("cur_a", cur_a, ea[7:0]);
    check("cur_b", cur_b, eb[7:0]);
    check("home_oe", {7'h0, flag_oe}, {7'h0, idx == 16});
    check("home_pin", {7'h0, flag_pin}, {7'h0, idx != 16});
    check("bridge_oe", {7'h0, bridge_oe}, {7'h0, en_pin & (stby == 0)});
    check("osc", {7'h0, osc}, {7'h0, stby == 0});
    check_phase("a", ea, a_pos, a_neg);
    check_phase("b", eb, b_pos, b_neg);
  endtask : check_all

  // Dropped steps (standby, warm-up, init held) leave the model untouched
  task automatic do_step();
    int g;
    int o;
    int t;
    host.step(12 + $urandom_range(8), 12 + $urandom_range(8));
    if (stby != 0 || init_pin) return;
    g = incs[res];
    o = (res == 1) ? 16 : 0;
    if (res != last) begin
      t = (idx - o + 128) % 128;
      t = t - t % g + (((t % g) * 2 >= g) ? g : 0);
      idx = (t + o) % 128;
    end else begin
      idx = (idx + (dir_pin ? g : 128 - g)) % 128;
    end
    last = res;
  endtask : do_step

  task automatic set_res(input int code);
    host.set_pins(dir_pin, 1'b1, code[2:0], 1'b0, 90);
    res = code;
  endtask : set_res

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int k;
    void'($urandom(32'h44fe));
    host.wait_clk(6);
    i_rstn <= 1'b1;
    k = 0;
    while (osc !== 1'b1 && k < 1000) begin
      host.wait_clk(1);
      k++;
    end
    if (k == 1000) begin
      n_mismatch++;
      end_of_test();
    end
    host.wait_clk(450);
    check_all();
    for (int m = 0; m < 8; m++) begin
      set_res(codes[m]);
      for (int b = 0; b < 3; b++) begin
        host.set_pins($urandom_range(1) == 1, $urandom_range(3) != 0, sel_pin, 1'b0, 10);
        repeat (1 + $urandom_range(5)) do_step();
        host.wait_clk(4);
        check_all();
      end
    end
    // Select glitches shorter than both filters change nothing
    host.set_pins(dir_pin, en_pin, 3'h0, init_pin, 20);
    host.set_pins(dir_pin, en_pin, 3'h7, init_pin, 10);
    do_step();
    host.wait_clk(4);
    check_all();
    for (int j = 0; j < 2; j++) begin
      set_res(inits[j]);
      do_step();
      do_step();
      host.set_pins(dir_pin, en_pin, sel_pin, 1'b1, 10);
      host.set_pins(dir_pin, en_pin, sel_pin, 1'b0, 45);
      check_all();
      host.set_pins(dir_pin, en_pin, sel_pin, 1'b1, 45);
      idx = 16;
      check_all();
      do_step();
      check_all();
      host.set_pins(dir_pin, en_pin, sel_pin, 1'b0, 45);
    end
    host.set_pins(dir_pin, 1'b0, sel_pin, 1'b0, 10);
    check_all();
    host.set_pins(dir_pin, 1'b1, 3'h0, 1'b0, 80);
    stby = 1;
    check_all();
    do_step();
    host.set_pins(dir_pin, 1'b1, 3'h7, 1'b0, 100);
    do_step();
    host.wait_clk(400);
    stby = 0;
    do_step();
    host.wait_clk(4);
    check_all();
    end_of_test();
  end
endmodule : step_dir_indexer_control_test
`default_nettype wire
